// ===== common/bctc_defs.vh
// bctc_defs.vh: constants for the bus cycle termination controller
// assumes inclusion by bare name from design files
`ifndef BCTC_DEFS_VH
`define BCTC_DEFS_VH

// ----------------------------------------
// termination codes
// ----------------------------------------
`define BCTC_TERM_NONE   3'h0
`define BCTC_TERM_NORMAL 3'h1
`define BCTC_TERM_HALT   3'h2
`define BCTC_TERM_BUS_ERROR_IN   3'h3
`define BCTC_TERM_RETRY  3'h4

// ----------------------------------------
// values and timing
// ----------------------------------------
`define BCTC_PRECHARGE     16'hffff
`define BCTC_MON_DEFAULT   8'h40
`define BCTC_SYNC_DELAY_NS 10
`define BCTC_CLK_PERIOD_NS 5
`define BCTC_SYNC_CYCLES   ((`BCTC_SYNC_DELAY_NS + `BCTC_CLK_PERIOD_NS - 1) / `BCTC_CLK_PERIOD_NS)

`endif

// ===== verilog/bctc_sync2.v
// bctc_sync2.v: two-flop synchroniser for pin inputs
// assumes a single system clock and synchronous reset
module bctc_sync2 #(
	parameter W = 1
) (
	input  wire         i_clk_sys,
	input  wire         i_srst,
	input  wire [W-1:0] i_async,
	input  wire [W-1:0] i_rst_val,
	output wire [W-1:0] o_sync
);
	reg [W-1:0] meta_q;
	reg [W-1:0] sync_q;

	// first stage only feeds the second stage
	always @(posedge i_clk_sys) begin
		if (i_srst) begin
			meta_q <= {W{1'b1}};
			sync_q <= {W{1'b1}};
		end else begin
			meta_q <= i_async;
			sync_q <= meta_q;
		end
	end

	assign o_sync = i_srst ? i_rst_val : sync_q;
endmodule // bctc_sync2

// ===== verilog/bctc_ctrl.v
// bctc_ctrl.v: external bus cycle termination and bus exception control
// assumes active-low pins from outside, synchronised here; one 200 MHz clock
`include "bctc_defs.vh"

// Contract
// - cycle ends normally only on a transfer ack line or autovector request
// - ack with error and halt negated gives normal termination
// - halt with ack and no error: end normally, halt until halt released
// - error without halt ends cycle, exception possibly deferred
// - error with halt ends cycle and retries after halt negates
// - sample ack, error, halt at even state and two states later
// - latch bus error at cycle end, defer exception processing
// - error-ended cycle captures no data; prefetch loads all ones
// - clear latched error when first handler instruction executes
// - double fault: second error early, error after reset, error in frame read
// - several errors in one instruction give a single exception after it
// - double fault halts, drives halt low, reset only, arbitration kept
// - errors after exception processing finished are not double faults
// - retry: strobes off, wait error and halt negated, delay, rerun same cycle
// - request with error and halt: release bus first, rerun after return
// - indivisible sequence: retry each access, keep flag, never release bus
// - halted after cycle: data floated, strobes off, address held
module bctc_ctrl #(
	parameter       DW         = 16,
	parameter [7:0] MON_CYCLES = `BCTC_MON_DEFAULT
) (
	input  wire          i_clk_sys,
	input  wire          i_srst,
	input  wire          i_cycle_req,
	input  wire          i_cycle_prefetch,
	input  wire          i_indivisible,
	input  wire          i_mon_enable,
	input  wire          i_instr_done,
	input  wire          i_handler_first,
	input  wire          i_frame_read,
	input  wire [DW-1:0] i_data_pin,
	input  wire [1:0]    i_transfer_ack_n,
	input  wire          i_autovector_request_n,
	input  wire          i_bus_error_in_n,
	input  wire          i_halt_n,
	input  wire          i_bus_request_n,
	input  wire          i_bus_grant_ack_n,
	output wire          o_cycle_busy,
	output wire          o_cycle_done,
	output reg  [2:0]    o_term_code,
	output reg  [DW-1:0] o_read_data,
	output wire          o_bus_error_in_exception,
	output wire          o_double_fault,
	output wire          o_address_strobe_n,
	output wire          o_data_strobe_n,
	output wire          o_data_oe,
	output wire          o_addr_oe,
	output wire          o_indivisible_cycle_flag_n,
	output wire          o_bus_grant_n,
	output wire          o_halt_out,
	output wire          o_halt_oe
);
	// ----------------------------------------
	// states
	// ----------------------------------------
	localparam [6:0] ST_IDLE  = 7'h01;
	localparam [6:0] ST_S0    = 7'h02;
	localparam [6:0] ST_WAIT  = 7'h04;
	localparam [6:0] ST_CONF  = 7'h08;
	localparam [6:0] ST_HOLD  = 7'h10;
	localparam [6:0] ST_REL   = 7'h20;
	localparam [6:0] ST_DEAD  = 7'h40;
	localparam integer SYNC_INT = `BCTC_SYNC_CYCLES;
	localparam [2:0] SYNC_CNT = SYNC_INT[2:0];

	reg [6:0]    state_q;
	reg [6:0]    state_d;
	reg [7:0]    mon_q;
	reg [2:0]    dly_q;
	reg          pend_q;
	reg          in_exc_q;
	reg          post_reset_q;
	reg          rerun_q;
	reg          rel_q;
	reg          first_ack_q;
	reg          done_q;
	reg [DW-1:0] data_q;
	wire [1:0]   ack_n;
	wire         autovector_request_n;
	wire         err_n;
	wire         halt_n;
	wire         br_n;
	wire         bgack_n;
	wire [DW-1:0] data_s;
	wire         mon_err;

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	bctc_sync2 #(.W(DW + 7)) u_sync (
		.i_clk_sys (i_clk_sys),
		.i_srst    (i_srst),
		.i_async   ({i_data_pin, i_transfer_ack_n, i_autovector_request_n,
		              i_bus_error_in_n, i_halt_n, i_bus_request_n, i_bus_grant_ack_n}),
		.i_rst_val ({{DW{1'b0}}, 6'h3f, 1'b1}),
		.o_sync    ({data_s, ack_n, autovector_request_n, err_n, halt_n, br_n, bgack_n})
	);

	function term_ack;
		input [1:0] a_n;
		input       v_n;
		begin
			term_ack = (a_n != 2'h3) | ~v_n;
		end
	endfunction

	wire ack_now  = term_ack(ack_n, autovector_request_n);
	// monitor error counts as an error line assertion
	wire err_now  = ~err_n | mon_err;
	wire halt_now = ~halt_n;
	wire dbl      = (state_q == ST_DEAD);

	assign mon_err = i_mon_enable & (mon_q >= MON_CYCLES);

	// ----------------------------------------
	// cycle sequencer
	// ----------------------------------------
	always @* begin
		state_d = state_q;
		case (state_q)
			ST_IDLE: begin
				if (rel_q)
					state_d = ST_REL;
				else if (i_cycle_req | rerun_q)
					state_d = ST_S0;
			end
			ST_S0: state_d = ST_WAIT;
			ST_WAIT: begin
				// state N sampled; confirm two states later
				if (ack_now | err_now)
					state_d = ST_CONF;
			end
			ST_CONF: begin
				if (dbl)
					state_d = ST_DEAD;
				else if (err_now & halt_now)
					state_d = ST_HOLD;
				else if (err_now)
					state_d = ST_IDLE;
				else if (halt_now)
					state_d = ST_HOLD;
				else if (ack_now)
					state_d = ST_IDLE;
				else
					state_d = ST_WAIT;
			end
			ST_HOLD: begin
				// wait for both lines negated, then sync delay
				if (~err_now & ~halt_now & (dly_q == SYNC_CNT))
					state_d = ST_IDLE;
			end
			ST_REL: begin
				if (~rel_q)
					state_d = ST_IDLE;
			end
			ST_DEAD: state_d = ST_DEAD;
			default: state_d = ST_IDLE;
		endcase
	end

	// double fault condition on an error-terminated cycle
	wire term_err = (state_q == ST_CONF) & err_now & ~halt_now;
	wire dbl_hit  = term_err & (in_exc_q | post_reset_q | i_frame_read);

	always @(posedge i_clk_sys) begin
		if (i_srst) begin
			state_q      <= ST_IDLE;
			mon_q        <= 8'h00;
			dly_q        <= 3'h0;
			pend_q       <= 1'b0;
			in_exc_q     <= 1'b0;
			post_reset_q <= 1'b1;
			rerun_q      <= 1'b0;
			rel_q        <= 1'b0;
			first_ack_q  <= 1'b0;
			done_q       <= 1'b0;
			data_q       <= {DW{1'b0}};
			o_term_code  <= `BCTC_TERM_NONE;
			o_read_data  <= {DW{1'b0}};
		end else begin
			state_q <= dbl_hit ? ST_DEAD : state_d;
			done_q  <= 1'b0;
			// keep counting through confirm so a monitor timeout is still seen there
			if (state_q == ST_WAIT || state_q == ST_CONF)
				mon_q <= mon_q + 8'h01;
			else
				mon_q <= 8'h00;
			if (state_q == ST_HOLD && !err_now && !halt_now)
				dly_q <= (dly_q == SYNC_CNT) ? 3'h0 : dly_q + 3'h1;
			else
				dly_q <= 3'h0;
			if (state_q == ST_WAIT) begin
				first_ack_q  <= ack_now;
				data_q       <= data_s;
			end
			if (state_q == ST_S0)
				rerun_q <= 1'b0;
			if (i_handler_first | i_instr_done)
				post_reset_q <= 1'b0;
			// clear on first handler instruction; a new hit in that cycle wins
			if (i_handler_first)
				in_exc_q <= 1'b0;
			if (i_instr_done & pend_q)
				in_exc_q <= 1'b1;
			if (i_instr_done)
				pend_q <= 1'b0;
			if (state_q == ST_CONF && !dbl_hit) begin
				done_q <= ~(err_now & halt_now);
				if (err_now & halt_now) begin
					o_term_code <= `BCTC_TERM_RETRY;
					rerun_q     <= 1'b1;
					// bus given away first if requested, unless locked sequence
					rel_q       <= ~br_n & ~i_indivisible;
				end else if (err_now) begin
					o_term_code <= `BCTC_TERM_BUS_ERROR_IN;
					pend_q      <= 1'b1;
					if (~br_n & ~i_indivisible) begin
						rerun_q <= 1'b1;
						rel_q   <= 1'b1;
					end
					if (i_cycle_prefetch)
						o_read_data <= `BCTC_PRECHARGE;
				end else if (ack_now | first_ack_q) begin
					o_term_code <= halt_now ? `BCTC_TERM_HALT : `BCTC_TERM_NORMAL;
					o_read_data <= data_q;
				end
			end
			if (state_q == ST_REL && br_n && bgack_n)
				rel_q <= 1'b0;
			if (state_q == ST_DEAD)
				o_term_code <= `BCTC_TERM_NONE;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	wire active = (state_q == ST_S0) | (state_q == ST_WAIT) | (state_q == ST_CONF);

	assign o_cycle_busy = ~(state_q == ST_IDLE);
	assign o_cycle_done = done_q;
	assign o_bus_error_in_exception = pend_q & i_instr_done;
	assign o_double_fault = dbl;
	// strobes inactive while halted or waiting retry
	assign o_address_strobe_n = ~active;
	assign o_data_strobe_n = ~((state_q == ST_WAIT) | (state_q == ST_CONF));
	assign o_data_oe = 1'b0;
	// address held while halted, floated only when the bus is granted
	assign o_addr_oe = ~(state_q == ST_REL) & bgack_n;
	assign o_indivisible_cycle_flag_n = ~i_indivisible;
	// arbitration still served while halted by double fault
	assign o_bus_grant_n = ~(((state_q == ST_REL) | (dbl | state_q == ST_IDLE) & ~rerun_q)
	                         & ~br_n & ~i_indivisible);
	assign o_halt_out = 1'b0;
	assign o_halt_oe  = dbl;
endmodule // bctc_ctrl

// ===== tb/bctc_sva.sv
// checker on the bctc_ctrl ports
// assumes one clock and a synchronous high reset
module bctc_sva (
	input logic       i_clk_sys,
	input logic       i_srst,
	input logic       i_indivisible,
	input logic       i_instr_done,
	input logic       o_cycle_busy,
	input logic       o_cycle_done,
	input logic [2:0] o_term_code,
	input logic       o_bus_error_in_exception,
	input logic       o_double_fault,
	input logic       o_address_strobe_n,
	input logic       o_data_strobe_n,
	input logic       o_data_oe,
	input logic       o_indivisible_cycle_flag_n,
	input logic       o_bus_grant_n,
	input logic       o_halt_out,
	input logic       o_halt_oe
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (i_srst);
	done_code_a: assert property (o_cycle_done |-> o_term_code inside {3'h1, 3'h2, 3'h3})
		else $error("done without final code");
	done_pulse_a: assert property (o_cycle_done |=> !o_cycle_done)
		else $error("done longer than one cycle");
	idle_strobe_a: assert property (!o_cycle_busy |-> o_address_strobe_n && o_data_strobe_n)
		else $error("strobe active while idle");
	ds_inside_a: assert property (!o_data_strobe_n |-> !o_address_strobe_n)
		else $error("data strobe without address strobe");
	data_float_a: assert property (!o_data_oe)
		else $error("data bus driven");
	fault_halt_a: assert property (o_double_fault |-> o_halt_oe && !o_halt_out ##1 o_double_fault)
		else $error("double fault not held with halt low");
	fault_quiet_a: assert property (o_double_fault |=> !o_cycle_done)
		else $error("cycle ended after double fault");
	rmc_flag_a: assert property (o_indivisible_cycle_flag_n == !i_indivisible)
		else $error("indivisible flag wrong");
	rmc_grant_a: assert property (i_indivisible && $past(i_indivisible) |-> o_bus_grant_n)
		else $error("bus granted inside indivisible sequence");
	exc_sync_a: assert property (o_bus_error_in_exception |-> i_instr_done)
		else $error("exception before instruction end");
endmodule // bctc_sva

bind bctc_ctrl bctc_sva u_sva (.*);

// ===== tb/bctc_peer.sv
// partner: peripheral, chip-select and bus-error logic on the pins
// assumes pull-ups on every termination line
module bctc_peer (
	input  logic        i_clk_sys,
	input  logic        i_as_n,
	input  logic        i_ds_n,
	input  logic [2:0]  i_mode,
	input  logic [15:0] i_word,
	output logic [1:0]  o_ack_n,
	output logic        o_autovector_request_n,
	output logic        o_bus_error_in_n,
	output logic        o_halt_n,
	output logic [15:0] o_data
);
	timeunit 1ns;
	timeprecision 100ps;
	// released bus shows the inverse so a stale capture is caught
	assign o_data = i_ds_n ? ~i_word : i_word;
	initial {o_ack_n, o_autovector_request_n, o_bus_error_in_n, o_halt_n} = 5'h1f;
	always @(posedge i_clk_sys) begin
		{o_ack_n, o_autovector_request_n, o_bus_error_in_n, o_halt_n} <= 5'h1f;
		if (!i_as_n) begin
			case (i_mode)
			3'h0: o_ack_n <= 2'h0;
			3'h1: {o_ack_n, o_halt_n} <= 3'h0;
			3'h2: o_bus_error_in_n <= 1'b0;
			3'h3: {o_bus_error_in_n, o_halt_n} <= 2'h0;
			3'h5: o_autovector_request_n <= 1'b0;
			default: ;
			endcase
		end
	end
endmodule // bctc_peer

// ===== tb/testbench.sv
// self-checking bench for bctc_ctrl
// assumes bctc_peer answers on the pins; monitor count shortened
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 0, srst = 1, req = 0, pf = 0, indivisible_cycle_flag = 0, mon = 0, idone = 0, hfirst = 0;
	logic br_n = 1, excs, autovector_request_n, bus_error_in_n, halt_n, busy, done, exc, dfault, as_n, ds_n;
	logic rmc_n, bg_n, hoe, aoe;
	logic [2:0] mode = 0, code;
	logic [1:0] ack_n;
	logic [15:0] word = 16'h1234, din, rd;
	int num_errors = 0, n_checks = 0, n_as = 0, n0;
	bctc_ctrl #(.DW(16), .MON_CYCLES(8'h10)) u_dut (.i_clk_sys(clk), .i_srst(srst),
		.i_cycle_req(req), .i_cycle_prefetch(pf), .i_indivisible(indivisible_cycle_flag), .i_mon_enable(mon),
		.i_instr_done(idone), .i_handler_first(hfirst), .i_frame_read(1'b0), .i_data_pin(din),
		.i_transfer_ack_n(ack_n), .i_autovector_request_n(autovector_request_n), .i_bus_error_in_n(bus_error_in_n),
		.i_halt_n(halt_n), .i_bus_request_n(br_n), .i_bus_grant_ack_n(1'b1),
		.o_cycle_busy(busy), .o_cycle_done(done), .o_term_code(code), .o_read_data(rd),
		.o_bus_error_in_exception(exc), .o_double_fault(dfault), .o_address_strobe_n(as_n),
		.o_data_strobe_n(ds_n), .o_data_oe(), .o_addr_oe(aoe), .o_indivisible_cycle_flag_n(rmc_n),
		.o_bus_grant_n(bg_n), .o_halt_out(), .o_halt_oe(hoe));
	bctc_peer u_peer (.i_clk_sys(clk), .i_as_n(as_n), .i_ds_n(ds_n), .i_mode(mode),
		.i_word(word), .o_ack_n(ack_n), .o_autovector_request_n(autovector_request_n), .o_bus_error_in_n(bus_error_in_n),
		.o_halt_n(halt_n), .o_data(din));
	initial forever #2.5 clk = ~clk;
	always @(negedge as_n) n_as++;
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rst;
		srst <= 1;
		repeat (2) @(posedge clk);
		srst <= 0;
		repeat (3) @(posedge clk);
	endtask
	// requests are only taken in idle, so wait out halt and retry holds too
	task automatic wt;
		int n;
		for (n = 0; n < 300 && done !== 1'b1 && dfault !== 1'b1; n++) @(posedge clk);
		if (n == 300) num_errors++;
		for (n = 0; n < 30 && busy !== 1'b0 && dfault !== 1'b1; n++) @(posedge clk);
		repeat (3) @(posedge clk);
	endtask
	// a retry repeats forever unless the far side relents after the first
	task automatic cyc(input logic [2:0] m);
		mode <= m;
		req <= 1;
		@(posedge clk) req <= 0;
		if (m == 3'h3) begin
			for (int n = 0; n < 300 && code !== 3'h4; n++) @(posedge clk);
			if (code !== 3'h4) num_errors++;
			mode <= 3'h0;
		end
		wt;
	endtask
	task automatic ins(input logic h);
		idone <= !h;
		hfirst <= h;
		#1 excs = exc;
		@(posedge clk);
		idone <= 0;
		hfirst <= 0;
	endtask
	task automatic t_norm;
		cyc(3'h0);
		chk(code, 3'h1);
		chk(rd, 16'h1234);
		cyc(3'h5);
		chk(code, 3'h1);
		ins(0);
	endtask
	task automatic t_halt;
		cyc(3'h1);
		chk(code, 3'h2);
		chk(aoe, 1'b1);
		cyc(3'h0);
		chk(code, 3'h1);
	endtask
	task automatic t_bus_error_in;
		word <= 16'h0f0f;
		cyc(3'h2);
		chk(code, 3'h3);
		chk(rd, 16'h1234);
		pf <= 1;
		cyc(3'h2);
		pf <= 0;
		chk(rd, 16'hffff);
		chk(exc, 1'b0);
		ins(0);
		chk(excs, 1'b1);
		ins(1);
		cyc(3'h2);
		chk(dfault, 1'b0);
		ins(0);
		ins(1);
		ins(0);
		chk(excs, 1'b0);
	endtask
	task automatic t_retry;
		n0 = n_as;
		cyc(3'h3);
		chk(code, 3'h1);
		chk(n_as - n0, 2);
	endtask
	task automatic t_mon;
		mon <= 1;
		cyc(3'h4);
		chk(code, 3'h3);
		ins(0);
		ins(1);
	endtask
	task automatic t_rmc;
		indivisible_cycle_flag <= 1;
		br_n <= 0;
		cyc(3'h0);
		chk(bg_n, 1'b1);
		chk(rmc_n, 1'b0);
		cyc(3'h2);
		chk(bg_n, 1'b1);
		ins(0);
		ins(1);
		indivisible_cycle_flag <= 0;
		repeat (8) @(posedge clk);
		chk(bg_n, 1'b0);
		br_n <= 1;
		repeat (8) @(posedge clk);
	endtask
	task automatic t_dflt;
		rst;
		cyc(3'h2);
		chk(dfault, 1'b1);
		chk(hoe, 1'b1);
		n0 = n_as;
		cyc(3'h0);
		chk(n_as - n0, 0);
		rst;
		chk(dfault, 1'b0);
	endtask
	task automatic tally_and_finish;
		if (num_errors == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		#200us;
		num_errors++;
		tally_and_finish;
	end
	initial begin
		rst;
		t_norm;
		t_halt;
		t_bus_error_in;
		t_retry;
		t_mon;
		t_rmc;
		t_dflt;
		tally_and_finish;
	end
endmodule // testbench
